// ---- hw/acc_pkg.sv ----
// constants and register map of the converter core and channel configuration block
// What this block does
// - lead code plus one core clocks early, or at start when lead code plus one reaches the conversion length
// - two-bit resolution field, resets to twelve bits
// - core clock equals twice divider source clocks, two for divider zero
// - per-channel level or edge trigger bit
// - per-channel early interrupt enable bit
// - per-channel early status, cleared by buffer read
// - per-channel differential mode bit
// - per-channel signed result format bit
// - mode odd bit, format even below
// - ready flag set when result available
package acc_pkg;
    localparam int          NUM_CORES     = 4;
    localparam int          NUM_CHANNELS  = 22;
    localparam int          ADDR_W        = 5;
    // register word addresses
    localparam logic [4:0]  ADDR_CORE0    = 5'h00;  // cores at 0..3
    localparam logic [4:0]  ADDR_LVL_LO   = 5'h04;
    localparam logic [4:0]  ADDR_LVL_HI   = 5'h05;
    localparam logic [4:0]  ADDR_EIE_LO   = 5'h06;
    localparam logic [4:0]  ADDR_EIE_HI   = 5'h07;
    localparam logic [4:0]  ADDR_EIS_LO   = 5'h08;
    localparam logic [4:0]  ADDR_EIS_HI   = 5'h09;
    localparam logic [4:0]  ADDR_MOD0_LO  = 5'h0a;
    localparam logic [4:0]  ADDR_MOD0_HI  = 5'h0b;
    localparam logic [4:0]  ADDR_MOD1_LO  = 5'h0c;
    localparam logic [4:0]  ADDR_RDY_LO   = 5'h0d;
    localparam logic [4:0]  ADDR_RDY_HI   = 5'h0e;
    localparam logic [4:0]  ADDR_BUF0     = 5'h10;  // result buffers at 16..37 span
    // core control field positions
    localparam int          DIV_LSB       = 0;
    localparam int          DIV_W         = 7;
    localparam int          RES_LSB       = 8;
    localparam int          LEAD_LSB      = 10;
    localparam logic [15:0] CORE_MASK     = 16'h1f7f;
    localparam logic [15:0] CORE_RESET    = 16'h0300;  // twelve-bit resolution
    localparam logic [15:0] HI_MASK       = 16'h003f;  // channels 21..16
    localparam logic [15:0] MOD1_MASK     = 16'h0fff;
    // conversion length in core clocks per resolution code
    localparam logic [3:0]  CONV_LEN_6    = 4'h6;
    localparam logic [3:0]  CONV_LEN_8    = 4'h8;
    localparam logic [3:0]  CONV_LEN_10   = 4'ha;
    localparam logic [3:0]  CONV_LEN_12   = 4'hc;
endpackage

// ---- hw/acc_top.sv ----
// converter core and channel configuration registers with early interrupt timing
`timescale 1ns/1ps
module acc_top (
    input  wire logic        i_clk,
    input  wire logic        i_rst_n,
    input  wire logic [5:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    input  wire logic [3:0]  i_conv_start,   // one pulse per core, starts a conversion
    input  wire logic [4:0]  i_conv_chan_0,
    input  wire logic [4:0]  i_conv_chan_1,
    input  wire logic [4:0]  i_conv_chan_2,
    input  wire logic [4:0]  i_conv_chan_3,
    output logic      [15:0] o_rdata,
    output logic      [21:0] o_level_trigger_en,
    output logic      [21:0] o_pair_input_mode,
    output logic      [21:0] o_signed_format,
    output logic      [21:0] o_early_irq,        // one-cycle pulse per channel
    output logic      [21:0] o_result_ready_flag,
    output logic      [3:0]  o_core_clock_tick   // one pulse per core clock period
);
    localparam int NC = acc_pkg::NUM_CORES;
    localparam int NCH = acc_pkg::NUM_CHANNELS;

    logic [15:0] core_ctl_q [NC];
    logic [21:0] lvl_q, eie_q, eis_q, rdy_q;
    logic [43:0] mode_q;
    logic [15:0] rdata_d, rdata_q;
    logic [21:0] early_q;
    logic [3:0]  tick_q;
    logic [4:0]  chan_in [NC];

    assign chan_in[0] = i_conv_chan_0;
    assign chan_in[1] = i_conv_chan_1;
    assign chan_in[2] = i_conv_chan_2;
    assign chan_in[3] = i_conv_chan_3;

    // write decode
    wire we_lvl_lo  = i_wr && (i_addr[4:0] == acc_pkg::ADDR_LVL_LO) && !i_addr[5];
    wire we_lvl_hi  = i_wr && (i_addr[4:0] == acc_pkg::ADDR_LVL_HI) && !i_addr[5];
    wire we_eie_lo  = i_wr && (i_addr[4:0] == acc_pkg::ADDR_EIE_LO) && !i_addr[5];
    wire we_eie_hi  = i_wr && (i_addr[4:0] == acc_pkg::ADDR_EIE_HI) && !i_addr[5];
    wire we_eis_lo  = i_wr && (i_addr[4:0] == acc_pkg::ADDR_EIS_LO) && !i_addr[5];
    wire we_eis_hi  = i_wr && (i_addr[4:0] == acc_pkg::ADDR_EIS_HI) && !i_addr[5];
    wire we_mod0_lo = i_wr && (i_addr[4:0] == acc_pkg::ADDR_MOD0_LO) && !i_addr[5];
    wire we_mod0_hi = i_wr && (i_addr[4:0] == acc_pkg::ADDR_MOD0_HI) && !i_addr[5];
    wire we_mod1_lo = i_wr && (i_addr[4:0] == acc_pkg::ADDR_MOD1_LO) && !i_addr[5];
    // buffer read index: address 16 onward maps channel 0..21
    wire [5:0] buf_idx  = i_addr - {1'b0, acc_pkg::ADDR_BUF0};
    wire       buf_rd   = i_rd && (i_addr >= {1'b0, acc_pkg::ADDR_BUF0})
                          && (buf_idx < 6'(NCH));
    wire [15:0] wlo     = i_wdata;
    wire [15:0] whi     = i_wdata & acc_pkg::HI_MASK;

    // per-channel early events and ready events gathered from cores
    logic [21:0] early_ev, ready_ev;
    logic [21:0] ev_early_core [NC];
    logic [21:0] ev_ready_core [NC];
    always_comb begin
        early_ev = '0;
        ready_ev = '0;
        for (int c = 0; c < NC; c++) begin
            early_ev = early_ev | ev_early_core[c];
            ready_ev = ready_ev | ev_ready_core[c];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : g_core
            logic [7:0] div_cnt_q;   // wide enough for the 254-clock period
            logic [3:0] conv_cnt_q;
            logic       busy_q;
            logic [4:0] chan_q;
            logic       early_done_q;
            wire  [6:0] divc   = core_ctl_q[g][acc_pkg::DIV_LSB +: acc_pkg::DIV_W];
            wire  [1:0] res    = core_ctl_q[g][acc_pkg::RES_LSB +: 2];
            wire  [2:0] lead   = core_ctl_q[g][acc_pkg::LEAD_LSB +: 3];
            wire  [7:0] period = (divc < 7'h02) ? 8'h02 : {divc, 1'b0};
            // compare with >= so a shorter divider written mid-count wraps at once
            wire        tick   = (div_cnt_q >= period - 8'h01);
            wire  [3:0] conv_len = (res == 2'b11) ? acc_pkg::CONV_LEN_12 :
                                   (res == 2'b10) ? acc_pkg::CONV_LEN_10 :
                                   (res == 2'b01) ? acc_pkg::CONV_LEN_8 :
                                                    acc_pkg::CONV_LEN_6;
            // lead time is code plus one
            wire  [3:0] lead_n   = {1'b0, lead} + 4'h1;
            // lead past start fires at start
            wire        start_now = i_conv_start[g] && !busy_q;
            // ready follows conv_cnt_q - 1 more core clocks, so fire at lead_n + 1
            wire        early_hit = busy_q && tick && !early_done_q
                                    && (conv_cnt_q <= lead_n + 4'h1);
            wire        early_go  = early_hit || (start_now && lead_n >= conv_len);
            wire        done      = busy_q && tick && (conv_cnt_q == 4'h1);
            wire  [4:0] chan_sel  = start_now ? chan_in[g] : chan_q;
            always_comb begin
                ev_early_core[g] = '0;
                ev_ready_core[g] = '0;
                if (early_go && chan_sel < 5'(NCH))
                    ev_early_core[g][chan_sel] = 1'b1;
                if (done && chan_q < 5'(NCH))
                    ev_ready_core[g][chan_q] = 1'b1;
            end
            // core clock divider and conversion countdown
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    div_cnt_q    <= '0;
                    conv_cnt_q   <= '0;
                    busy_q       <= 1'b0;
                    chan_q       <= '0;
                    early_done_q <= 1'b0;
                end else begin
                    div_cnt_q <= tick ? 8'h00 : div_cnt_q + 8'h01;
                    if (start_now) begin
                        busy_q       <= 1'b1;
                        conv_cnt_q   <= conv_len;
                        chan_q       <= chan_in[g];
                        early_done_q <= early_go;
                    end else if (busy_q && tick) begin
                        conv_cnt_q   <= conv_cnt_q - 4'h1;
                        early_done_q <= early_done_q | early_hit;
                        busy_q       <= (conv_cnt_q != 4'h1);
                    end
                end
            end
            always_ff @(posedge i_clk) begin
                if (!i_rst_n)
                    tick_q[g] <= 1'b0;
                else
                    tick_q[g] <= tick;
            end
            // core control register write
            wire we_core = i_wr && !i_addr[5]
                           && (i_addr[4:0] == acc_pkg::ADDR_CORE0 + 5'(g));
            always_ff @(posedge i_clk) begin
                if (!i_rst_n)
                    core_ctl_q[g] <= acc_pkg::CORE_RESET;
                else if (we_core)
                    core_ctl_q[g] <= i_wdata & acc_pkg::CORE_MASK;
            end
        end
    endgenerate

    wire [21:0] early_gated = early_ev & eie_q;
    logic [21:0] buf_clr;
    always_comb begin
        buf_clr = '0;
        if (buf_rd)
            buf_clr[buf_idx[4:0]] = 1'b1;
    end
    wire [21:0] eis_wr = {we_eis_hi ? whi[5:0] : eis_q[21:16],
                          we_eis_lo ? wlo : eis_q[15:0]};
    wire [21:0] eis_d  = (eis_wr & ~buf_clr) | early_gated;
    // ready set at result, read clears
    wire [21:0] rdy_d  = (rdy_q & ~buf_clr) | ready_ev;

    // configuration and status registers
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            lvl_q   <= '0;
            eie_q   <= '0;
            eis_q   <= '0;
            rdy_q   <= '0;
            mode_q  <= '0;
            early_q <= '0;
        end else begin
            if (we_lvl_lo) lvl_q[15:0]  <= wlo;
            if (we_lvl_hi) lvl_q[21:16] <= whi[5:0];
            if (we_eie_lo) eie_q[15:0]  <= wlo;
            if (we_eie_hi) eie_q[21:16] <= whi[5:0];
            if (we_mod0_lo) mode_q[15:0]  <= wlo;
            if (we_mod0_hi) mode_q[31:16] <= wlo;
            if (we_mod1_lo) mode_q[43:32] <= 12'(wlo & acc_pkg::MOD1_MASK);
            eis_q   <= eis_d;
            rdy_q   <= rdy_d;
            early_q <= early_gated;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        if (i_rd && !i_addr[5]) begin
            unique case (i_addr[4:0])
                acc_pkg::ADDR_LVL_LO:  rdata_d = lvl_q[15:0];
                acc_pkg::ADDR_LVL_HI:  rdata_d = {10'h000, lvl_q[21:16]};
                acc_pkg::ADDR_EIE_LO:  rdata_d = eie_q[15:0];
                acc_pkg::ADDR_EIE_HI:  rdata_d = {10'h000, eie_q[21:16]};
                acc_pkg::ADDR_EIS_LO:  rdata_d = eis_q[15:0];
                acc_pkg::ADDR_EIS_HI:  rdata_d = {10'h000, eis_q[21:16]};
                acc_pkg::ADDR_MOD0_LO: rdata_d = mode_q[15:0];
                acc_pkg::ADDR_MOD0_HI: rdata_d = mode_q[31:16];
                acc_pkg::ADDR_MOD1_LO: rdata_d = {4'h0, mode_q[43:32]};
                acc_pkg::ADDR_RDY_LO:  rdata_d = rdy_q[15:0];
                acc_pkg::ADDR_RDY_HI:  rdata_d = {10'h000, rdy_q[21:16]};
                default: begin
                    if (i_addr[4:0] < acc_pkg::ADDR_LVL_LO)
                        rdata_d = core_ctl_q[i_addr[1:0]];
                    else
                        rdata_d = '0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n)
            rdata_q <= '0;
        else
            rdata_q <= rdata_d;
    end

    // per-channel mode split: odd bit mode, even bit format
    logic [21:0] pair_w, sign_w;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign pair_w[g] = mode_q[2*g+1];
            assign sign_w[g] = mode_q[2*g];
        end
    endgenerate

    logic [21:0] pair_q, sign_q, lvl_out_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            pair_q    <= '0;
            sign_q    <= '0;
            lvl_out_q <= '0;
        end else begin
            pair_q    <= pair_w;
            sign_q    <= sign_w;
            lvl_out_q <= lvl_q;
        end
    end

    assign o_rdata             = rdata_q;
    assign o_level_trigger_en  = lvl_out_q;
    assign o_pair_input_mode   = pair_q;
    assign o_signed_format     = sign_q;
    assign o_early_irq         = early_q;
    assign o_result_ready_flag = rdy_q;
    assign o_core_clock_tick   = tick_q;
endmodule

// ---- test/acc_top_asserts.sv ----
// bound assertions for the converter configuration block
`timescale 1ns/1ps
module acc_top_asserts (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic [5:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [15:0] o_rdata,
    input wire logic [21:0] o_level_trigger_en,
    input wire logic [21:0] o_pair_input_mode,
    input wire logic [21:0] o_signed_format,
    input wire logic [21:0] o_early_irq,
    input wire logic [3:0]  o_core_clock_tick
);
    // single clock domain, reset masks every property
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // read data only in the cycle after a read strobe
    property p_rd_idle; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_core_zero;
        $past(i_rd) && $past(i_addr) < 6'h04 |-> (o_rdata & ~acc_pkg::CORE_MASK) == 16'h0000;
    endproperty
    a_core_zero: assert property (p_core_zero) else $error("core spare bits set");
    property p_hi_zero;
        $past(i_rd) && $past(i_addr) inside {6'h05, 6'h07, 6'h09} |-> o_rdata[15:6] == 10'h000;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("upper spare bits set");
    // configuration reaches the outputs two edges after the write
    property p_lvl_lo;
        i_wr && i_addr == 6'h04 |-> ##2 o_level_trigger_en[15:0] == $past(i_wdata, 2);
    endproperty
    a_lvl_lo: assert property (p_lvl_lo) else $error("level bits wrong");
    property p_lvl_hi;
        i_wr && i_addr == 6'h05 |-> ##2 o_level_trigger_en[21:16] == $past(i_wdata[5:0], 2);
    endproperty
    a_lvl_hi: assert property (p_lvl_hi) else $error("upper level bits wrong");
    property p_mode;
        i_wr && i_addr == 6'h0a |-> ##2 {o_pair_input_mode[1:0], o_signed_format[1:0]} ==
            {$past(i_wdata[3], 2), $past(i_wdata[1], 2), $past(i_wdata[2], 2), $past(i_wdata[0], 2)};
    endproperty
    a_mode: assert property (p_mode) else $error("mode bit placement wrong");
    property p_tick; o_core_clock_tick[0] |=> !o_core_clock_tick[0]; endproperty
    a_tick: assert property (p_tick) else $error("core clock under two cycles");
    property p_irq; (o_early_irq & $past(o_early_irq)) == 22'h000000; endproperty
    a_irq: assert property (p_irq) else $error("early pulse too long");
    // main scenarios seen
    c_irq: cover property (o_early_irq[5]);
    c_mode: cover property (i_wr && i_addr == 6'h0a);
    c_tick: cover property (o_core_clock_tick[0]);
endmodule
bind acc_top acc_top_asserts acc_top_asserts_inst (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .o_level_trigger_en, .o_pair_input_mode, .o_signed_format, .o_early_irq,
    .o_core_clock_tick);

// ---- test/acc_top_test.sv ----
// self-checking bench for the converter configuration block
`timescale 1ns/1ps
module acc_top_test;
    logic        i_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic [5:0]  i_addr = 6'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic [3:0]  i_conv_start = 4'h0;
    logic [4:0]  i_conv_chan_0 = 5'h00;
    logic [15:0] o_rdata;
    logic [21:0] o_level_trigger_en, o_pair_input_mode, o_signed_format;
    logic [21:0] o_early_irq, o_result_ready_flag;
    logic [3:0]  o_core_clock_tick;
    logic [5:0]  wa[6] = '{6'h01, 6'h04, 6'h05, 6'h07, 6'h0c, 6'h0f};
    logic [15:0] we[6] = '{16'h1f7f, 16'hffff, 16'h003f, 16'h003f, 16'h0fff, 16'h0000};
    logic [6:0]  dv[4] = '{7'h00, 7'h01, 7'h03, 7'h7f};
    int          dp[4] = '{2, 2, 6, 254};
    int          ln[4] = '{acc_pkg::CONV_LEN_6, acc_pkg::CONV_LEN_8,
                           acc_pkg::CONV_LEN_10, acc_pkg::CONV_LEN_12};
    int          bad_count = 0;
    int          checked = 0;
    int          ti, tr;
    int          tk[$];
    // 100 MHz source clock
    always #5 i_clk = ~i_clk;
    acc_top acc_top_inst (.i_clk, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd, .i_conv_start,
        .i_conv_chan_0, .i_conv_chan_1(5'h00), .i_conv_chan_2(5'h00), .i_conv_chan_3(5'h00),
        .o_rdata, .o_level_trigger_en, .o_pair_input_mode, .o_signed_format, .o_early_irq,
        .o_result_ready_flag, .o_core_clock_tick);
    // compare and count
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    // one-cycle register write
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // read, data taken in the following cycle
    task automatic rc(input string nm, input logic [5:0] a, input logic [15:0] e);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(nm, e, o_rdata);
    endtask
    // convert channel 5 on core 0, note early pulse and ready cycles
    task automatic conv(output int t_irq, output int t_rdy);
        @(posedge i_clk);
        i_conv_chan_0 <= 5'h05;
        i_conv_start <= 4'h1;
        t_irq = -1;
        t_rdy = -1;
        for (int n = 0; n < 3000 && t_rdy < 0; n++) begin
            @(posedge i_clk);
            i_conv_start <= 4'h0;
            #1;
            if (o_early_irq[5] === 1'b1) t_irq = n;
            if (o_result_ready_flag[5] === 1'b1) t_rdy = n;
        end
    endtask
    // verdict and end of run
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rc("core reset", 6'h00, 16'h0300);
        for (int a = 4; a < 13; a++) rc("reset", 6'(a), 16'h0000);
        for (int k = 0; k < 6; k++) begin
            wr(wa[k], 16'hffff);
            rc("mask", wa[k], we[k]);
        end
        chk("level", 22'h3fffff, o_level_trigger_en);
        wr(6'h0a, 16'h00b4);
        repeat (2) @(posedge i_clk);
        #1 chk("pair_input_mode", 10'h3fc, {o_pair_input_mode[21:16], o_pair_input_mode[3:0]});
        chk("sign", 10'h3f6, {o_signed_format[21:16], o_signed_format[3:0]});
        wr(6'h06, 16'h0020);
        // legal leads only at full resolution
        for (int l = 0; l < 6; l++) begin
            wr(6'h00, {3'b000, 3'(l), 10'h302});
            conv(ti, tr);
            chk("lead", l + 1, (tr - ti + 2) / 4);
            rc("status", 6'h08, 16'h0020);
            rc("ready", 6'h0d, 16'h0020);
            rc("buffer", 6'h15, 16'h0000);
            rc("cleared", 6'h08, 16'h0000);
        end
        for (int r = 0; r < 4; r++) begin
            wr(6'h00, {6'h00, 2'(r), 8'h02});
            conv(ti, tr);
            chk("length", 1, tr >= ln[r] * 4 - 3 && tr <= ln[r] * 4);
            rc("buffer", 6'h15, 16'h0000);
        end
        wr(6'h00, 16'h1c02);
        conv(ti, tr);
        chk("lead at start", 1, ti >= 0 && ti < 6);
        rc("buffer", 6'h15, 16'h0000);
        wr(6'h06, 16'h0000);
        wr(6'h00, 16'h0302);
        conv(ti, tr);
        chk("masked", 32'hffffffff, ti);
        rc("status off", 6'h08, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            wr(6'h00, {9'h006, dv[k]});
            tk.delete();
            while (tk.size() < 3) begin
                @(posedge i_clk);
                #1;
                if (o_core_clock_tick[0] === 1'b1) tk.push_back(int'($time / 10));
            end
            chk("tick", dp[k], tk[2] - tk[1]);
        end
        end_of_test();
    end
    // cut a hang short
    initial begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        end_of_test();
    end
endmodule
